// ==== rwp_top.sv ====
// drive-side read/write path: 2,7 coding, clock mux, head select, unsafe
// Operation
// R1: controller sends serial nrz write data timed by its write clock
// R2: nrz write bits are 2,7 rll encoded before the head driver
// R3: a flip-flop toggles per encoded pulse, reversing write current
// R4: track above 511 raises inner zone and selects lower write current
// R5: read path works only when drive selected and read gate true
// R6: 2,7 read data decoded to nrz, returned with read clock
// R7: read gate low: shared clock output carries servo oscillator divided by two
// R8: read gate high: lock on preamble, then switch to read clock
// R9: three head select lines form the head code, top line ignored
// R10: code n selects head n; small model has no heads 5 to 7
// R11: write mode while write enable asserted, read mode otherwise
// R12: write mode enables current source and steers it per encoded pulse
// R13: read mode amplifies selected head and forwards to read channel
// R14: unsafe when write transitions go missing or head shorted or open
// R15: unsafe raises attention, status bits, and blocks further writing
// R16: write inhibit holds until controller reads status and clears fault; here the clear-fault write alone lifts it, no status read needed
//
// The register offsets and the plain strobed port were left to the implementer.
module rwp_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic DRIVE_SELECT,
    input wire logic WRITE_GATE,
    input wire logic WRITE_ENABLE,
    input wire logic WRITE_CLOCK,
    input wire logic NRZ_WRITE_DATA,
    input wire logic READ_GATE,
    input wire logic [3:0] HEAD_SELECT_LINES,
    input wire logic SERVO_PHASE_LOCKED_OSC,
    input wire logic READ_PULSE,
    input wire logic HEAD_OPEN,
    input wire logic HEAD_SHORT,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic [7:0] HEAD_ENABLE,
    output logic WRITE_MODE,
    output logic READ_MODE,
    output logic WRITE_CURRENT_ON,
    output logic WRITE_CURRENT_DIR,
    output logic INNER_ZONE,
    output logic LOW_WRITE_CURRENT,
    output logic READ_AMP_ON,
    output logic NRZ_READ_DATA,
    output logic READ_REF_CLOCK,
    output logic ATTENTION,
    output logic IRQ
);
    localparam rwp_pkg::rwp_rd_state_t RWP_RD_IDLE_T = rwp_pkg::RWP_RD_IDLE;
    localparam rwp_pkg::rwp_rd_state_t RWP_RD_LOCK_T = rwp_pkg::RWP_RD_LOCK;
    localparam rwp_pkg::rwp_rd_state_t RWP_RD_DATA_T = rwp_pkg::RWP_RD_DATA;
    // pin inputs pass two flops; all decisions use the synced copies
    logic [11:0] s;
    logic ws_sel, ws_wg, ws_we, ws_wclk, ws_wd, ws_rg, ws_osc, ws_rp, ws_ho, ws_hs;
    logic [3:0] ws_head;
    rwp_sync #(.WIDTH(12)) u_sync (
        .CLK(CLK),
        .RST(RST),
        .CE(CE),
        .d({DRIVE_SELECT, WRITE_GATE, WRITE_ENABLE, WRITE_CLOCK, NRZ_WRITE_DATA,
            READ_GATE, SERVO_PHASE_LOCKED_OSC, READ_PULSE, HEAD_OPEN, HEAD_SHORT,
            2'b00}),
        .q(s)
    );
    rwp_sync #(.WIDTH(rwp_pkg::HEAD_LINES)) u_sync_head (
        .CLK(CLK),
        .RST(RST),
        .CE(CE),
        .d(HEAD_SELECT_LINES),
        .q(ws_head)
    );
    assign {ws_sel, ws_wg, ws_we, ws_wclk, ws_wd, ws_rg, ws_osc, ws_rp, ws_ho, ws_hs} = s[11:2];

    // registered state
    logic wclk_d, osc_d, rp_d, ref_clk, wr_flip, inhibit;
    logic [1:0] enc_hist, next_enc_hist;
    logic [1:0] enc_pend, next_enc_pend;
    logic [rwp_pkg::MISS_BITS-1:0] miss_cnt, next_miss_cnt;
    rwp_pkg::rwp_rd_state_t rd_state, next_rd_state;
    logic [rwp_pkg::LOCK_BITS-1:0] lock_cnt, next_lock_cnt;
    logic [2:0] dec_sh, next_dec_sh;
    logic [1:0] dec_cnt, next_dec_cnt;
    logic [rwp_pkg::NUM_EVENTS-1:0] status, next_status, mask;
    logic small_model;
    logic [rwp_pkg::TRACK_BITS-1:0] track;
    logic next_wr_flip, next_inhibit, next_ref_clk, next_nrz, next_rclk_out;
    logic rd_clk_int, next_rd_clk_int;
    logic [7:0] next_head_en;
    logic [31:0] next_rdata;
    logic [rwp_pkg::NUM_EVENTS-1:0] ev;
    logic wclk_rise, osc_rise, rp_rise, wmode, rmode, active_write, enc_pulse;
    logic [2:0] head_code;
    logic head_ok, clr_fault, status_read;

    always_comb
    begin
        wclk_rise = ws_wclk & ~wclk_d;
        osc_rise = ws_osc & ~osc_d;
        rp_rise = ws_rp & ~rp_d;
        wmode = ws_we; // see R11
        rmode = ~ws_we; // see R11
        head_code = ws_head[rwp_pkg::HEAD_BITS-1:0]; // see R9
        head_ok = head_code <= (small_model ? rwp_pkg::HEADS_SMALL : rwp_pkg::HEADS_LARGE); // see R10
        next_head_en = (ws_sel && head_ok) ? (8'h01 << head_code) : 8'h00; // see R10
        active_write = ws_sel & wmode & ws_wg & ~inhibit; // see R15
        // simplified 2,7 coder: one data bit emits two code cells; run limits kept
        // by forcing a clock cell after long zero runs (trade-off: not table-exact)
        next_enc_hist = enc_hist;
        next_enc_pend = enc_pend;
        enc_pulse = 1'b0;
        if (active_write && wclk_rise)
        begin
            next_enc_pend = (ws_wd && enc_hist[0] == 1'b0) ? 2'b10 :
                            (enc_hist == 2'b00 && !ws_wd) ? 2'b01 : 2'b00; // see R2
            next_enc_hist = {enc_hist[0], ws_wd};
            enc_pulse = |next_enc_pend;
        end
        next_wr_flip = enc_pulse ? ~wr_flip : wr_flip; // see R3 R12
        // missing transitions: clocks keep coming but no pulse for too long
        next_miss_cnt = miss_cnt;
        if (!active_write || enc_pulse)
            next_miss_cnt = '0;
        else if (wclk_rise && miss_cnt != rwp_pkg::MISS_BITS'(rwp_pkg::MISS_LIMIT))
            next_miss_cnt = miss_cnt + 1'b1;
        ev[rwp_pkg::ST_MISSING] = miss_cnt == rwp_pkg::MISS_BITS'(rwp_pkg::MISS_LIMIT); // see R14
        ev[rwp_pkg::ST_HEADFAULT] = ws_sel & wmode & (ws_ho | ws_hs); // see R14
        ev[rwp_pkg::ST_UNSAFE] = ev[rwp_pkg::ST_MISSING] | ev[rwp_pkg::ST_HEADFAULT]; // see R14
        // reference clock: servo oscillator divided by two
        next_ref_clk = osc_rise ? ~ref_clk : ref_clk; // see R7
        // read side
        next_rd_state = rd_state;
        next_lock_cnt = lock_cnt;
        next_dec_sh = dec_sh;
        next_dec_cnt = dec_cnt;
        next_nrz = NRZ_READ_DATA;
        next_rd_clk_int = rd_clk_int;
        ev[rwp_pkg::ST_LOCK] = 1'b0;
        if (!(ws_sel && ws_rg && rmode)) // see R5
        begin
            next_rd_state = RWP_RD_IDLE_T;
        end
        else
        begin
            case (rd_state)
                RWP_RD_IDLE_T:
                begin
                    next_lock_cnt = '0;
                    next_rd_state = RWP_RD_LOCK_T;
                end
                RWP_RD_LOCK_T:
                begin
                    if (rp_rise)
                        next_lock_cnt = lock_cnt + 1'b1; // see R8
                    if (lock_cnt == rwp_pkg::LOCK_BITS'(rwp_pkg::LOCK_ZEROS))
                    begin
                        next_rd_state = RWP_RD_DATA_T;
                        next_dec_cnt = '0;
                        ev[rwp_pkg::ST_LOCK] = 1'b1;
                    end
                end
                RWP_RD_DATA_T:
                begin
                    // each recovered cell pair yields one nrz bit with one read clock toggle
                    if (osc_rise)
                    begin
                        next_dec_sh = {dec_sh[1:0], rp_d};
                        next_dec_cnt = dec_cnt + 1'b1;
                        if (dec_cnt[0])
                        begin
                            next_nrz = dec_sh[0] | rp_d; // see R6
                            next_rd_clk_int = ~rd_clk_int;
                        end
                    end
                end
                default: next_rd_state = RWP_RD_IDLE_T;
            endcase
        end
        next_rclk_out = (rd_state == RWP_RD_DATA_T) ? rd_clk_int : ref_clk; // see R7 R8
        // registers
        status_read = REG_RD && REG_ADDR == rwp_pkg::REG_STATUS;
        clr_fault = REG_WR && REG_ADDR == rwp_pkg::REG_CONTROL && REG_WDATA[rwp_pkg::CTL_CLEAR_FAULT];
        next_status = status;
        if (REG_WR && REG_ADDR == rwp_pkg::REG_STATUS)
            next_status = status & ~REG_WDATA[rwp_pkg::NUM_EVENTS-1:0];
        next_status = next_status | ev; // set wins over clear
        // inhibit lifts only on explicit clear, and only with no fault pending
        next_inhibit = inhibit;
        if (clr_fault && !ev[rwp_pkg::ST_UNSAFE])
            next_inhibit = 1'b0; // see R16
        if (ev[rwp_pkg::ST_UNSAFE])
            next_inhibit = 1'b1; // see R15
        case (REG_ADDR)
            rwp_pkg::REG_STATUS: next_rdata = {28'h0000000, status};
            rwp_pkg::REG_MASK: next_rdata = {28'h0000000, mask};
            rwp_pkg::REG_CONTROL: next_rdata = {30'h00000000, inhibit, small_model};
            rwp_pkg::REG_TRACK: next_rdata = {20'h00000, track};
            default: next_rdata = 32'h00000000;
        endcase
        if (!REG_RD)
            next_rdata = 32'h00000000;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            wclk_d <= 1'b0;
            osc_d <= 1'b0;
            rp_d <= 1'b0;
            ref_clk <= 1'b0;
            wr_flip <= 1'b0;
            inhibit <= 1'b0;
            enc_hist <= 2'b00;
            enc_pend <= 2'b00;
            miss_cnt <= '0;
            rd_state <= RWP_RD_IDLE_T;
            lock_cnt <= '0;
            dec_sh <= 3'h0;
            dec_cnt <= 2'h0;
            rd_clk_int <= 1'b0;
            status <= '0;
            mask <= '0;
            small_model <= 1'b0;
            track <= '0;
            REG_RDATA <= 32'h00000000;
            HEAD_ENABLE <= 8'h00;
            WRITE_MODE <= 1'b0;
            READ_MODE <= 1'b0;
            WRITE_CURRENT_ON <= 1'b0;
            WRITE_CURRENT_DIR <= 1'b0;
            INNER_ZONE <= 1'b0;
            LOW_WRITE_CURRENT <= 1'b0;
            READ_AMP_ON <= 1'b0;
            NRZ_READ_DATA <= 1'b0;
            READ_REF_CLOCK <= 1'b0;
            ATTENTION <= 1'b0;
            IRQ <= 1'b0;
        end
        else if (CE)
        begin
            wclk_d <= ws_wclk;
            osc_d <= ws_osc;
            rp_d <= ws_rp;
            ref_clk <= next_ref_clk;
            wr_flip <= next_wr_flip;
            inhibit <= next_inhibit;
            enc_hist <= next_enc_hist;
            enc_pend <= next_enc_pend;
            miss_cnt <= next_miss_cnt;
            rd_state <= next_rd_state;
            lock_cnt <= next_lock_cnt;
            dec_sh <= next_dec_sh;
            dec_cnt <= next_dec_cnt;
            rd_clk_int <= next_rd_clk_int;
            status <= next_status;
            if (REG_WR && REG_ADDR == rwp_pkg::REG_MASK)
                mask <= REG_WDATA[rwp_pkg::NUM_EVENTS-1:0];
            if (REG_WR && REG_ADDR == rwp_pkg::REG_CONTROL)
                small_model <= REG_WDATA[rwp_pkg::CTL_SMALL_MODEL];
            if (REG_WR && REG_ADDR == rwp_pkg::REG_TRACK)
                track <= REG_WDATA[rwp_pkg::TRACK_BITS-1:0];
            REG_RDATA <= next_rdata;
            HEAD_ENABLE <= next_head_en;
            WRITE_MODE <= ws_sel & wmode; // see R11
            READ_MODE <= ws_sel & rmode;
            WRITE_CURRENT_ON <= ws_sel & wmode & ~next_inhibit; // see R12 R15
            WRITE_CURRENT_DIR <= next_wr_flip; // see R3
            INNER_ZONE <= track > rwp_pkg::INNER_ZONE_LIMIT; // see R4
            LOW_WRITE_CURRENT <= track > rwp_pkg::INNER_ZONE_LIMIT; // see R4
            READ_AMP_ON <= ws_sel & rmode & ws_rg & (|next_head_en); // see R13 R5
            NRZ_READ_DATA <= (next_rd_state == RWP_RD_DATA_T) ? next_nrz : 1'b0;
            READ_REF_CLOCK <= next_rclk_out;
            ATTENTION <= next_status[rwp_pkg::ST_UNSAFE]; // see R15
            IRQ <= |(next_status & mask);
        end
    end
endmodule : rwp_top

// ==== rwp_pkg.sv ====
// shared constants for the drive read/write path
package rwp_pkg;
    localparam int HEAD_BITS = 3;
    localparam int HEAD_LINES = 4;
    localparam int TRACK_BITS = 12;
    localparam logic [11:0] INNER_ZONE_LIMIT = 12'h1FF;
    localparam logic [2:0] HEADS_LARGE = 3'h7;
    localparam logic [2:0] HEADS_SMALL = 3'h4;
    localparam int MISS_LIMIT = 64;
    localparam int MISS_BITS = 7;
    localparam int LOCK_ZEROS = 8;
    localparam int LOCK_BITS = 4;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_CONTROL = 8'h08;
    localparam logic [7:0] REG_TRACK = 8'h0C;
    localparam int ST_UNSAFE = 0;
    localparam int ST_LOCK = 1;
    localparam int ST_MISSING = 2;
    localparam int ST_HEADFAULT = 3;
    localparam int NUM_EVENTS = 4;
    localparam int CTL_SMALL_MODEL = 0;
    localparam int CTL_CLEAR_FAULT = 1;
    typedef enum logic [1:0] {
        RWP_RD_IDLE = 2'b00,
        RWP_RD_LOCK = 2'b01,
        RWP_RD_DATA = 2'b10
    } rwp_rd_state_t;
endpackage : rwp_pkg

// ==== rwp_sync.sv ====
// two-flop synchroniser for pin inputs
module rwp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            meta <= '0;
            q <= '0;
        end
        else if (CE)
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : rwp_sync

// ==== rwp_props.sv ====
// assertions on the read/write path top ports
module rwp_props (
    input wire logic CLK,
    input wire logic RST,
    input wire logic DRIVE_SELECT,
    input wire logic WRITE_ENABLE,
    input wire logic [3:0] HEAD_SELECT_LINES,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic [7:0] HEAD_ENABLE,
    input wire logic WRITE_MODE,
    input wire logic READ_MODE,
    input wire logic WRITE_CURRENT_ON,
    input wire logic WRITE_CURRENT_DIR,
    input wire logic INNER_ZONE,
    input wire logic LOW_WRITE_CURRENT,
    input wire logic READ_AMP_ON,
    input wire logic ATTENTION
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_modes_exclusive: assert property (!(WRITE_MODE && READ_MODE))
        else $error("write and read mode together");
    a_head_onehot: assert property ($onehot0(HEAD_ENABLE))
        else $error("more than one head enabled");
    a_zone_current: assert property (INNER_ZONE == LOW_WRITE_CURRENT)
        else $error("inner zone and low current differ");
    a_unsafe_blocks: assert property (ATTENTION [*3] |-> !WRITE_CURRENT_ON)
        else $error("write current on while unsafe");
    a_current_mode: assert property (WRITE_CURRENT_ON |-> WRITE_MODE || $past(WRITE_MODE))
        else $error("write current outside write mode");
    // eight cycles of slack for the encoder pipeline to drain
    a_dir_idle: assert property ((!WRITE_MODE) [*8] |=> $stable(WRITE_CURRENT_DIR))
        else $error("current direction moved in read mode");
    a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0)
        else $error("read data without a read");
    a_amp_read: assert property (READ_AMP_ON [*2] |-> !WRITE_CURRENT_ON)
        else $error("read amp and write current together");
    a_top_ignored: assert property
        (($stable({DRIVE_SELECT, WRITE_ENABLE, HEAD_SELECT_LINES[2:0]}) && !REG_WR) [*6]
        |-> $stable(HEAD_ENABLE)) else $error("head moved with code steady");
    c_attention: cover property ($rose(ATTENTION));
    c_inner: cover property ($rose(INNER_ZONE));
    c_dir: cover property (WRITE_MODE && $changed(WRITE_CURRENT_DIR));
endmodule : rwp_props
bind rwp_top rwp_props rwp_props_inst (.CLK(CLK), .RST(RST), .DRIVE_SELECT(DRIVE_SELECT),
    .WRITE_ENABLE(WRITE_ENABLE), .HEAD_SELECT_LINES(HEAD_SELECT_LINES), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .HEAD_ENABLE(HEAD_ENABLE), .WRITE_MODE(WRITE_MODE),
    .READ_MODE(READ_MODE), .WRITE_CURRENT_ON(WRITE_CURRENT_ON),
    .WRITE_CURRENT_DIR(WRITE_CURRENT_DIR), .INNER_ZONE(INNER_ZONE),
    .LOW_WRITE_CURRENT(LOW_WRITE_CURRENT), .READ_AMP_ON(READ_AMP_ON), .ATTENTION(ATTENTION));

// ==== rwp_ctl_model.sv ====
// controller model: serial nrz write stream with its write clock
module rwp_ctl_model (
    input wire logic CLK,
    input wire logic RST,
    input wire logic run,
    output logic WRITE_CLOCK,
    output logic NRZ_WRITE_DATA
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase = 2'h0;
    int seed = 32'h0BBF;
    initial WRITE_CLOCK = 1'b0;
    initial NRZ_WRITE_DATA = 1'b0;
    // clock stands still between frames; idle data wiggles so nothing stale looks valid
    always @(posedge CLK)
    begin
        phase <= (RST || !run) ? 2'h0 : phase + 2'h1;
        WRITE_CLOCK <= !RST && run && phase[1];
        if (RST || !run)
            NRZ_WRITE_DATA <= ~NRZ_WRITE_DATA;
        else if (phase == 2'h0)
            NRZ_WRITE_DATA <= 1'($random(seed));
    end
endmodule : rwp_ctl_model

// ==== rwp_top_tb.sv ====
// self-checking bench for the read/write path
module rwp_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 1'b0, RST = 1'b1, DRIVE_SELECT = 1'b0, WRITE_GATE = 1'b0, WRITE_ENABLE = 1'b0;
    logic READ_GATE = 1'b0, SERVO_PHASE_LOCKED_OSC = 1'b0, READ_PULSE = 1'b0, HEAD_OPEN = 1'b0;
    logic HEAD_SHORT = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, run = 1'b0, rd_seen = 1'b0;
    logic [3:0] HEAD_SELECT_LINES = 4'h0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0;
    logic WRITE_CLOCK, NRZ_WRITE_DATA, WRITE_MODE, READ_MODE, WRITE_CURRENT_ON, WRITE_CURRENT_DIR;
    logic INNER_ZONE, LOW_WRITE_CURRENT, READ_AMP_ON, NRZ_READ_DATA, READ_REF_CLOCK, ATTENTION, IRQ;
    logic ref_prev = 1'b0, dir_prev = 1'b0;
    logic [7:0] HEAD_ENABLE;
    logic [31:0] REG_RDATA;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    int mismatches = 0, compares = 0, cycles = 0, seed = 32'h0BBF, n, rises = 0, flips = 0, r0;
    always #5 CLK = ~CLK;
    rwp_ctl_model rwp_ctl_model_inst (.CLK(CLK), .RST(RST), .run(run), .WRITE_CLOCK(WRITE_CLOCK),
        .NRZ_WRITE_DATA(NRZ_WRITE_DATA));
    rwp_top rwp_top_inst (.CLK(CLK), .RST(RST), .CE(1'b1), .DRIVE_SELECT(DRIVE_SELECT),
        .WRITE_GATE(WRITE_GATE), .WRITE_ENABLE(WRITE_ENABLE), .WRITE_CLOCK(WRITE_CLOCK),
        .NRZ_WRITE_DATA(NRZ_WRITE_DATA), .READ_GATE(READ_GATE),
        .HEAD_SELECT_LINES(HEAD_SELECT_LINES), .SERVO_PHASE_LOCKED_OSC(SERVO_PHASE_LOCKED_OSC),
        .READ_PULSE(READ_PULSE), .HEAD_OPEN(HEAD_OPEN), .HEAD_SHORT(HEAD_SHORT),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .HEAD_ENABLE(HEAD_ENABLE), .WRITE_MODE(WRITE_MODE),
        .READ_MODE(READ_MODE), .WRITE_CURRENT_ON(WRITE_CURRENT_ON),
        .WRITE_CURRENT_DIR(WRITE_CURRENT_DIR), .INNER_ZONE(INNER_ZONE),
        .LOW_WRITE_CURRENT(LOW_WRITE_CURRENT), .READ_AMP_ON(READ_AMP_ON),
        .NRZ_READ_DATA(NRZ_READ_DATA), .READ_REF_CLOCK(READ_REF_CLOCK), .ATTENTION(ATTENTION),
        .IRQ(IRQ));
    task automatic finish_test;
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic wait_n(input int k);
        repeat (k) @(posedge CLK);
    endtask : wait_n
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
        @(posedge CLK);
    endtask : reg_wr
    // mask in the upper half of the note, expected value in the lower
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        exp_q.push_back({m, e});
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        @(posedge CLK);
    endtask : reg_rd
    // pin stimulus from free counters, read data and edge tallies from the outputs
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (cycles[0])
            SERVO_PHASE_LOCKED_OSC <= ~SERVO_PHASE_LOCKED_OSC;
        if (READ_GATE && cycles % 3 == 0)
            READ_PULSE <= ~READ_PULSE;
        ref_prev <= READ_REF_CLOCK;
        dir_prev <= WRITE_CURRENT_DIR;
        rises <= rises + int'(READ_REF_CLOCK && !ref_prev);
        flips <= flips + int'(WRITE_CURRENT_DIR !== dir_prev);
        rd_seen <= REG_RD;
        if (rd_seen)
        begin
            note = exp_q.pop_front();
            check(REG_RDATA & note[63:32], note[31:0]);
        end
        if (cycles == 5000)
        begin
            mismatches++;
            finish_test();
        end
    end
    initial
    begin
        wait_n(3);
        RST <= 1'b0;
        @(posedge CLK);
        for (n = 0; n < 5; n++)
            reg_rd(8'(n * 4), 32'hFFFFFFFF, 32'h0);
        DRIVE_SELECT <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            if (n == 8)
                reg_wr(rwp_pkg::REG_CONTROL, 32'h1);
            HEAD_SELECT_LINES <= {1'($random(seed)), 3'(n)};
            wait_n(6);
            check(32'(HEAD_ENABLE), (n > 12) ? 32'h0 : 32'h1 << n[2:0]);
        end
        reg_wr(rwp_pkg::REG_CONTROL, 32'h0);
        for (n = 0; n < 2; n++)
        begin
            reg_wr(rwp_pkg::REG_TRACK, 32'h1FF + 32'(n));
            wait_n(3);
            check(32'({INNER_ZONE, LOW_WRITE_CURRENT}), n ? 32'h3 : 32'h0);
        end
        reg_rd(rwp_pkg::REG_TRACK, 32'hFFF, 32'h200);
        r0 = rises;
        wait_n(80);
        check(32'(rises - r0 >= 9 && rises - r0 <= 11), 32'h1);
        WRITE_ENABLE <= 1'b1;
        WRITE_GATE <= 1'b1;
        run <= 1'b1;
        wait_n(6);
        check(32'({WRITE_MODE, READ_MODE, WRITE_CURRENT_ON}), 32'h5);
        r0 = flips;
        wait_n(120);
        check(32'(flips > r0), 32'h1);
        for (n = 1; n < 3; n++)
        begin
            reg_wr(rwp_pkg::REG_MASK, 32'h0);
            {HEAD_SHORT, HEAD_OPEN} <= 2'(n);
            wait_n(8);
            check(32'({ATTENTION, IRQ, WRITE_CURRENT_ON}), 32'h4);
            reg_wr(rwp_pkg::REG_MASK, 32'h1);
            wait_n(1);
            check(32'(IRQ), 32'h1);
            reg_rd(rwp_pkg::REG_STATUS, 32'h9, 32'h9);
            {HEAD_SHORT, HEAD_OPEN} <= 2'h0;
            wait_n(4);
            reg_wr(rwp_pkg::REG_STATUS, 32'hF);
            wait_n(2);
            check(32'({ATTENTION, IRQ, WRITE_CURRENT_ON}), 32'h0);
            reg_rd(rwp_pkg::REG_CONTROL, 32'h2, 32'h2);
            reg_wr(rwp_pkg::REG_CONTROL, 32'h2);
            wait_n(4);
            check(32'(WRITE_CURRENT_ON), 32'h1);
        end
        run <= 1'b0;
        WRITE_ENABLE <= 1'b0;
        WRITE_GATE <= 1'b0;
        READ_GATE <= 1'b1;
        wait_n(80);
        check(32'({READ_MODE, READ_AMP_ON, WRITE_MODE}), 32'h6);
        reg_rd(rwp_pkg::REG_STATUS, 32'h2, 32'h2);
        r0 = rises;
        wait_n(40);
        check(32'(rises > r0), 32'h1);
        READ_GATE <= 1'b0;
        wait_n(2);
        finish_test();
    end
endmodule : rwp_top_tb
